/* hw/rst_ctrl.sv */
/*
 * Reset source and sleep-recovery controller. Filters the external reset
 * pin, drives it open-drain as an indicator, sequences reset holds and
 * wake from sleep, and keeps the reset cause status register on APB.
 * Assumes inputs synchronous to clk and an oscillator tick input.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns

// Behaviour
// - pin low four clocks starts reset; three clocks may or may not.
// - stay in reset while pin low; leave on first edge after release.
// - external pin reset sets external_reset_flag.
// - pin is open-drain reset output during reset or when enabled.
// - internal reset events pull pin low until the hold has elapsed.
// - debugger request resets all but debugger, self-clears, sets power_on_flag.
// - wake hold is 66 or 5000 oscillator cycles plus start-up time.
// - wake touches only watchdog and oscillator control; oscillator selected.
// - after reset or wake, fetch vector at bytes 0002H and 0003H.
// - every completed wake sets sleep_wake_flag.
// - sleep wake sources: watchdog, pin change wake; reset or debug pin resets.
// - watchdog timeout in sleep wakes and sets watchdog and sleep flags.
// - any enabled port pin level change in sleep starts wake.
// - port capture disabled in sleep; only held levels get recorded.
// - reset pin in sleep must pass glitch filter of minimum width.
// - low_voltage_flag is live, unlatched, unaffected by reads or writes.
// - low-voltage detection is inactive when brownout detector disabled.
// - status is read-only at FF0H; a read clears bits 7 to 4.
// - cause flags encode power-on, pin, watchdog and wake kinds.
// - power_on_flag cleared by watchdog or wake; sleep flag by POR, awake watchdog.
// - watchdog and external flags cleared by POR or pin-change wake.
module rst_ctrl #(
    parameter int PORT_W      = 8,
    parameter int SLEEP_FILT  = 8,
    parameter int HOLD_LONG_P = rst_ctrl_pkg::HOLD_LONG
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst_b,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // External reset pin, open drain.
    input  wire logic              resetPinIn,
    output logic                   resetPinOut,
    output logic                   resetPinOe,
    // Debug pin and analog detectors.
    input  wire logic              debugPinIn,
    input  wire logic              porEvent,
    input  wire logic              brownoutEnable,
    input  wire logic              lowVoltage,
    // Oscillator cycle tick.
    input  wire logic              oscTick,
    // Watchdog and core state.
    input  wire logic              wdogTimeout,
    input  wire logic              wdogResetMode,
    input  wire logic              sleepEnter,
    // Port wake.
    input  wire logic [PORT_W-1:0] portPins,
    input  wire logic [PORT_W-1:0] portWakeEn,
    // Core controls.
    output rst_ctrl_pkg::core_ctl_t coreCtl,
    output logic      [15:0]       vectorAddr
);

    rst_ctrl_pkg::seq_state_t state;
    rst_ctrl_pkg::cause_t     pendCause;
    logic [3:0]               cause;
    logic [1:0]               ctrl;
    logic                     dbgReq;
    logic [2:0]               pinLowCnt;
    logic [7:0]               sleepLowCnt;
    logic [13:0]              holdCnt;
    logic [PORT_W-1:0]        portLast;
    logic                     pinFiltered;
    logic                     sleepPinReset;
    logic                     portChange;
    logic                     wdogSleep;
    logic                     statusRead;
    logic                     apbWrite;
    logic                     holdDone;
    logic                     internalEvt;
    logic [13:0]              holdTarget;

    // Address decode used by read and write paths.
    function automatic logic isAddr(input logic [11:0] a, input logic [11:0] r);
        isAddr = (a == r);
    endfunction

    // Zero wait states: every access completes in its first access cycle.
    assign pready     = 1'b1;
    assign statusRead = psel && penable && !pwrite && isAddr(paddr, rst_ctrl_pkg::STATUS_ADDR);
    assign apbWrite   = psel && penable && pwrite;

    // Unmapped addresses answer with an error.
    assign pslverr = psel && penable &&
                     !(isAddr(paddr, rst_ctrl_pkg::STATUS_ADDR) ||
                       isAddr(paddr, rst_ctrl_pkg::CONTROL_ADDR) ||
                       isAddr(paddr, rst_ctrl_pkg::DEBUG_ADDR));

    // Read data mux; reserved bits come back zero.
    always_comb begin
        prdata = 32'h0000_0000;
        if (isAddr(paddr, rst_ctrl_pkg::STATUS_ADDR)) begin
            prdata[7:4] = cause;
            prdata[rst_ctrl_pkg::LVD_BIT] = lowVoltage && brownoutEnable;
        end else if (isAddr(paddr, rst_ctrl_pkg::CONTROL_ADDR)) begin
            prdata[1:0] = ctrl;
        end else if (isAddr(paddr, rst_ctrl_pkg::DEBUG_ADDR)) begin
            prdata[0] = dbgReq;
        end
    end

    // Control register; writes to the status address are for the watchdog
    // control register and change nothing here.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= rst_ctrl_pkg::CTRL_RESET;
        end else if (apbWrite && isAddr(paddr, rst_ctrl_pkg::CONTROL_ADDR)) begin
            ctrl <= pwdata[1:0];
        end
    end

    // Debugger request: set by write, cleared once the reset hold begins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dbgReq <= 1'b0;
        end else if (apbWrite && isAddr(paddr, rst_ctrl_pkg::DEBUG_ADDR) && pwdata[0]) begin
            dbgReq <= 1'b1;
        end else if (state == rst_ctrl_pkg::ST_HOLD) begin
            dbgReq <= 1'b0;
        end
    end

    // Awake pin filter counts consecutive low clocks; four starts reset.
    // Our own drive is not counted, so the indicator cannot reset the device while awake; the sleep filter does count it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinLowCnt <= 3'h0;
        end else if (resetPinIn || resetPinOe || state == rst_ctrl_pkg::ST_SLEEP) begin
            pinLowCnt <= 3'h0;
        end else if (pinLowCnt != 3'(rst_ctrl_pkg::PIN_FILTER)) begin
            pinLowCnt <= pinLowCnt + 3'h1;
        end
    end
    assign pinFiltered = (pinLowCnt == 3'(rst_ctrl_pkg::PIN_FILTER));

    // Sleep glitch filter: wider, sized by parameter.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleepLowCnt <= 8'h00;
        end else if (resetPinIn || state != rst_ctrl_pkg::ST_SLEEP) begin
            sleepLowCnt <= 8'h00;
        end else if (sleepLowCnt != 8'(SLEEP_FILT)) begin
            sleepLowCnt <= sleepLowCnt + 8'h01;
        end
    end
    assign sleepPinReset = (sleepLowCnt == 8'(SLEEP_FILT));

    // Port levels are sampled on sleep entry; any enabled change after wakes.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            portLast <= '0;
        end else if (state != rst_ctrl_pkg::ST_SLEEP) begin
            portLast <= portPins;
        end
    end
    assign portChange = (state == rst_ctrl_pkg::ST_SLEEP) &&
                        |((portPins ^ portLast) & portWakeEn);
    assign wdogSleep  = (state == rst_ctrl_pkg::ST_SLEEP) && wdogTimeout;

    // Internal reset sources while awake; debug pin resets from sleep.
    assign internalEvt = porEvent || dbgReq ||
                         (wdogTimeout && wdogResetMode && state == rst_ctrl_pkg::ST_RUN) ||
                         (!debugPinIn && state == rst_ctrl_pkg::ST_SLEEP);

    // Hold length chosen by crystal enable; wake adds start-up time.
    assign holdTarget = ctrl[rst_ctrl_pkg::XTAL_BIT] ? 14'(HOLD_LONG_P) :
                        14'(rst_ctrl_pkg::HOLD_SHORT);
    assign holdDone   = (holdCnt >= holdTarget);

    // Sequencer; counting is in oscillator ticks, start-up in clocks.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state   <= rst_ctrl_pkg::ST_HOLD;
            holdCnt <= 14'h0000;
        end else begin
            case (state)
                rst_ctrl_pkg::ST_RUN: begin
                    holdCnt <= 14'h0000;
                    if (pinFiltered || internalEvt) begin
                        state <= rst_ctrl_pkg::ST_HOLD;
                    end else if (sleepEnter) begin
                        state <= rst_ctrl_pkg::ST_SLEEP;
                    end
                end
                rst_ctrl_pkg::ST_HOLD: begin
                    if (oscTick && !holdDone) begin
                        holdCnt <= holdCnt + 14'h0001;
                    end
                    if (holdDone) begin
                        state <= rst_ctrl_pkg::ST_WAITP;
                    end
                end
                rst_ctrl_pkg::ST_WAITP: begin
                    if (resetPinIn) begin
                        state <= rst_ctrl_pkg::ST_RUN;
                    end
                end
                rst_ctrl_pkg::ST_SLEEP: begin
                    holdCnt <= 14'h0000;
                    if (sleepPinReset || internalEvt) begin
                        state <= rst_ctrl_pkg::ST_HOLD;
                    end else if (wdogSleep || portChange) begin
                        state <= rst_ctrl_pkg::ST_WSTRT;
                    end
                end
                rst_ctrl_pkg::ST_WSTRT: begin
                    holdCnt <= holdCnt + 14'h0001;
                    if (holdCnt == 14'(rst_ctrl_pkg::OSC_START_CYC - 1)) begin
                        holdCnt <= 14'h0000;
                        state   <= rst_ctrl_pkg::ST_WHOLD;
                    end
                end
                rst_ctrl_pkg::ST_WHOLD: begin
                    if (oscTick && !holdDone) begin
                        holdCnt <= holdCnt + 14'h0001;
                    end
                    if (holdDone) begin
                        state <= rst_ctrl_pkg::ST_RUN;
                    end
                end
                default: begin
                    state <= rst_ctrl_pkg::ST_HOLD;
                end
            endcase
        end
    end

    // Remember which kind of reset is in progress.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pendCause <= rst_ctrl_pkg::CAUSE_POR;
        end else if (state == rst_ctrl_pkg::ST_RUN || state == rst_ctrl_pkg::ST_SLEEP) begin
            if (porEvent || dbgReq || (!debugPinIn && state == rst_ctrl_pkg::ST_SLEEP)) begin
                pendCause <= rst_ctrl_pkg::CAUSE_POR;
            end else if (wdogTimeout && wdogResetMode && state == rst_ctrl_pkg::ST_RUN) begin
                pendCause <= rst_ctrl_pkg::CAUSE_WDOG;
            end else if (pinFiltered || sleepPinReset) begin
                pendCause <= rst_ctrl_pkg::CAUSE_PIN;
            end
        end
    end

    // Cause flags: events set, a read clears; an event in the read cycle wins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cause <= rst_ctrl_pkg::CAUSE_RESET;
        end else if (state == rst_ctrl_pkg::ST_WAITP && resetPinIn) begin
            case (pendCause)
                rst_ctrl_pkg::CAUSE_PIN:  cause <= 4'h1;
                rst_ctrl_pkg::CAUSE_WDOG: cause <= 4'h2;
                default:                  cause <= 4'h8;
            endcase
        end else if (state == rst_ctrl_pkg::ST_SLEEP && wdogSleep && !sleepPinReset
                     && !internalEvt) begin
            cause <= 4'h6;
        end else if (state == rst_ctrl_pkg::ST_SLEEP && portChange && !sleepPinReset
                     && !internalEvt) begin
            cause <= 4'h4;
        end else if (state == rst_ctrl_pkg::ST_RUN && wdogTimeout && !wdogResetMode) begin
            cause <= (cause & 4'h3) | 4'h2;
        end else if (statusRead) begin
            cause <= 4'h0;
        end
    end

    // Pin drives low during any reset hold or when software enables it.
    assign resetPinOut = 1'b0;
    assign resetPinOe  = (state == rst_ctrl_pkg::ST_HOLD) ||
                         ctrl[rst_ctrl_pkg::PINOE_BIT];

    // Core controls; wake keeps registers other than watchdog/oscillator control.
    always_comb begin
        coreCtl.sysReset      = (state == rst_ctrl_pkg::ST_HOLD) ||
                                (state == rst_ctrl_pkg::ST_WAITP);
        coreCtl.wakeReset     = (state == rst_ctrl_pkg::ST_WSTRT) ||
                                (state == rst_ctrl_pkg::ST_WHOLD);
        coreCtl.cpuReset      = coreCtl.sysReset || coreCtl.wakeReset ||
                                (state == rst_ctrl_pkg::ST_SLEEP);
        coreCtl.vectorFetch   = (state == rst_ctrl_pkg::ST_WAITP && resetPinIn) ||
                                (state == rst_ctrl_pkg::ST_WHOLD && holdDone);
        coreCtl.wdogIrqReq    = (state == rst_ctrl_pkg::ST_WHOLD) && holdDone &&
                                !wdogResetMode && cause[1];
        coreCtl.portCaptureEn = (state == rst_ctrl_pkg::ST_RUN);
    end

    // Vector address for the fetch; low byte follows.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vectorAddr <= 16'h0000;
        end else begin
            vectorAddr <= rst_ctrl_pkg::VEC_HI_ADDR;
        end
    end

    // Checks.
    sequence s_pin_low4;
        (state == rst_ctrl_pkg::ST_RUN && !resetPinIn && !resetPinOe)[*4];
    endsequence

    property p_pin_filter;
        @(posedge clk) disable iff (!rst_b)
        s_pin_low4 |=> ##1 state == rst_ctrl_pkg::ST_HOLD;
    endproperty
    a_pin_filter: assert property (p_pin_filter) else $error("pin low 4 clocks no reset");

    property p_wait_pin;
        @(posedge clk) disable iff (!rst_b)
        state == rst_ctrl_pkg::ST_WAITP && !resetPinIn |=> state == rst_ctrl_pkg::ST_WAITP;
    endproperty
    a_wait_pin: assert property (p_wait_pin) else $error("left reset with pin low");

    property p_pin_drive;
        @(posedge clk) disable iff (!rst_b)
        state == rst_ctrl_pkg::ST_HOLD |-> resetPinOe && !resetPinOut;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin not driven in hold");

    property p_read_clear;
        @(posedge clk) disable iff (!rst_b)
        statusRead && state == rst_ctrl_pkg::ST_RUN && !wdogTimeout |=> cause == 4'h0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_lvd_gate;
        @(posedge clk) disable iff (!rst_b)
        !brownoutEnable && isAddr(paddr, rst_ctrl_pkg::STATUS_ADDR) |-> !prdata[0];
    endproperty
    a_lvd_gate: assert property (p_lvd_gate) else $error("lvd active with detector off");

    property p_wdog_wake;
        @(posedge clk) disable iff (!rst_b)
        wdogSleep && !sleepPinReset && !internalEvt |=> cause == 4'h6;
    endproperty
    a_wdog_wake: assert property (p_wdog_wake) else $error("watchdog wake flags wrong");

    property p_port_wake;
        @(posedge clk) disable iff (!rst_b)
        portChange && !wdogSleep && !sleepPinReset && !internalEvt
        |=> state == rst_ctrl_pkg::ST_WSTRT && cause == 4'h4;
    endproperty
    a_port_wake: assert property (p_port_wake) else $error("pin change did not wake");

    property p_capture_off;
        @(posedge clk) disable iff (!rst_b)
        state == rst_ctrl_pkg::ST_SLEEP |-> !coreCtl.portCaptureEn;
    endproperty
    a_capture_off: assert property (p_capture_off) else $error("capture on in sleep");

    property p_dbg_clear;
        @(posedge clk) disable iff (!rst_b)
        state == rst_ctrl_pkg::ST_HOLD && !apbWrite |=> !dbgReq;
    endproperty
    a_dbg_clear: assert property (p_dbg_clear) else $error("request not cleared");

endmodule

/* inc/rst_ctrl_pkg.sv */
/*
 * Package for the reset and sleep-recovery controller: register offsets,
 * status field positions, sequencer states and timing counts.
 * Assumes a 250 MHz system clock and an APB register bus.
 */
package rst_ctrl_pkg;

    // Byte address of the reset cause status register.
    localparam logic [11:0] STATUS_ADDR    = 12'hFF0;
    // Control register of our own: bit 0 crystal enable, bit 1 pin output enable.
    localparam logic [11:0] CONTROL_ADDR   = 12'hFF4;
    // Debugger control register of our own: bit 0 requests a reset.
    localparam logic [11:0] DEBUG_ADDR     = 12'hFF8;

    // Status field positions.
    localparam int POR_BIT   = 7;
    localparam int SLEEP_BIT = 6;
    localparam int WDOG_BIT  = 5;
    localparam int EXT_BIT   = 4;
    localparam int LVD_BIT   = 0;

    // Control field positions.
    localparam int XTAL_BIT  = 0;
    localparam int PINOE_BIT = 1;

    // Reset values.
    localparam logic [3:0] CAUSE_RESET = 4'h8;
    localparam logic [1:0] CTRL_RESET  = 2'h0;

    // Hold counts in oscillator cycles.
    localparam int HOLD_SHORT = 66;
    localparam int HOLD_LONG  = 5000;

    // Oscillator start-up time and its cycle count at 4 ns.
    localparam int OSC_START_NS  = 4000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int OSC_START_CYC = OSC_START_NS / CLK_PERIOD_NS;

    // Pin filter width in normal operation.
    localparam int PIN_FILTER = 4;

    // Reset vector byte addresses.
    localparam logic [15:0] VEC_HI_ADDR = 16'h0002;
    localparam logic [15:0] VEC_LO_ADDR = 16'h0003;

    // Sequencer states, Gray coded on each step except ST_SLEEP to ST_HOLD; the returns to ST_RUN are not.
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_HOLD  = 3'b001,
        ST_WAITP = 3'b011,
        ST_SLEEP = 3'b010,
        ST_WSTRT = 3'b110,
        ST_WHOLD = 3'b111
    } seq_state_t;

    // Reset cause kinds.
    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_POR  = 3'h1,
        CAUSE_PIN  = 3'h2,
        CAUSE_WDOG = 3'h3,
        CAUSE_DBG  = 3'h4
    } cause_t;

    // Outputs toward the core.
    typedef struct packed {
        logic        cpuReset;
        logic        sysReset;
        logic        wakeReset;
        logic        vectorFetch;
        logic        wdogIrqReq;
        logic        portCaptureEn;
    } core_ctl_t;

endpackage

/* tb/reset_source_and_stop_recovery_tb_top.sv */
/*
 * Directed bench for the reset and sleep-recovery controller over APB.
 * Assumes zero-wait APB and a shortened long hold count to keep the run brief.
 */
`timescale 1ns/1ns
module reset_source_and_stop_recovery_tb_top;
    localparam logic [11:0] ST = rst_ctrl_pkg::STATUS_ADDR;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pinLevel;
    logic        pinOe;
    logic        pinOut;
    logic        oscTick;
    logic        extLow = 1'b0;
    logic        debugPinIn = 1'b1;
    logic        porEvent = 1'b0;
    logic        brownoutEnable = 1'b0;
    logic        lowVoltage = 1'b0;
    logic        wdogTimeout = 1'b0;
    logic        wdogResetMode = 1'b1;
    logic        sleepEnter = 1'b0;
    logic [7:0]  portPins = 8'h00;
    logic [7:0]  portWakeEn = 8'h01;
    logic [15:0] vectorAddr;
    logic [31:0] rd;
    logic        err;
    int          badCount = 0;
    int          checked = 0;
    rst_ctrl_pkg::core_ctl_t coreCtl;

    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    rst_ctrl #(.HOLD_LONG_P(20)) DUT (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .resetPinIn(pinLevel),
        .resetPinOut(pinOut), .resetPinOe(pinOe), .debugPinIn(debugPinIn),
        .porEvent(porEvent), .brownoutEnable(brownoutEnable), .lowVoltage(lowVoltage),
        .oscTick(oscTick), .wdogTimeout(wdogTimeout), .wdogResetMode(wdogResetMode),
        .sleepEnter(sleepEnter), .portPins(portPins), .portWakeEn(portWakeEn),
        .coreCtl(coreCtl), .vectorAddr(vectorAddr));
    rst_far_side far (.clk(clk), .rst_b(rst_b), .pinOe(pinOe), .pinOut(pinOut),
        .extLow(extLow), .pinLevel(pinLevel), .oscTick(oscTick));

    // Compares one observed value with its expected value.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads one register and compares it.
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    // Waits, bounded, until the core leaves reset; a hang is counted.
    task automatic wait_idle();
        int n;
        n = 0;
        while (coreCtl.cpuReset !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        chk("reset released", 32'(n < 4000), 32'h1);
    endtask

    // Raises sleepEnter for one cycle and lets the state settle.
    task automatic go_sleep();
        @(posedge clk);
        sleepEnter <= 1'b1;
        @(posedge clk);
        sleepEnter <= 1'b0;
        @(posedge clk);
    endtask

    // Power-on cause, then a read clears the cause bits.
    task automatic t_por();
        wait_idle();
        rdchk(ST, 32'h80, "status after power-on");
        rdchk(ST, 32'h00, "status after read");
    endtask

    // Pin held low past the hold, then released.
    task automatic t_pin();
        @(posedge clk);
        extLow <= 1'b1;
        repeat (7) @(posedge clk);
        chk("pin driven in reset", 32'(pinOe), 32'h1);
        repeat (200) @(posedge clk);
        chk("held while pin low", 32'(coreCtl.cpuReset), 32'h1);
        extLow <= 1'b0;
        repeat (2) @(posedge clk);
        chk("leaves after release", 32'(coreCtl.cpuReset), 32'h0);
        rdchk(ST, 32'h10, "status after pin reset");
    endtask

    // Watchdog reset in run mode drives the pin through the hold.
    task automatic t_wdog();
        @(posedge clk);
        wdogTimeout <= 1'b1;
        @(posedge clk);
        wdogTimeout <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pin driven on watchdog", 32'(pinOe), 32'h1);
        wait_idle();
        rdchk(ST, 32'h20, "status after watchdog reset");
    endtask

    // Debugger request resets and clears itself.
    task automatic t_dbg();
        apb(1'b1, rst_ctrl_pkg::CONTROL_ADDR, 32'h1);
        apb(1'b1, rst_ctrl_pkg::DEBUG_ADDR, 32'h1);
        repeat (60) @(posedge clk);
        chk("crystal hold", 32'(coreCtl.cpuReset), 32'h0);
        wait_idle();
        apb(1'b1, rst_ctrl_pkg::CONTROL_ADDR, 32'h0);
        rdchk(rst_ctrl_pkg::DEBUG_ADDR, 32'h0, "debug request");
        rdchk(ST, 32'h80, "status after debugger reset");
    endtask

    // Pin change wake; called with a rising and then a falling level.
    task automatic t_wake(input logic [7:0] v);
        go_sleep();
        chk("capture off in sleep", 32'(coreCtl.portCaptureEn), 32'h0);
        portPins <= v;
        repeat (3) @(posedge clk);
        chk("wake started", 32'(coreCtl.cpuReset), 32'h1);
        chk("wake reset", 32'(coreCtl.wakeReset), 32'h1);
        wait_idle();
        chk("vector address", 32'(vectorAddr), 32'h2);
        rdchk(ST, 32'h40, "status after pin wake");
    endtask

    // Watchdog timeout in sleep, interrupt mode.
    task automatic t_wwake();
        int n;
        wdogResetMode <= 1'b0;
        go_sleep();
        wdogTimeout <= 1'b1;
        @(posedge clk);
        wdogTimeout <= 1'b0;
        n = 0;
        while (coreCtl.vectorFetch !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        chk("watchdog interrupt", 32'(coreCtl.wdogIrqReq), 32'h1);
        wait_idle();
        rdchk(ST, 32'h60, "status after watchdog wake");
    endtask

    // A short pin glitch in sleep is ignored; the debug pin and a long pin low reset.
    task automatic t_glitch();
        go_sleep();
        extLow <= 1'b1;
        repeat (3) @(posedge clk);
        extLow <= 1'b0;
        repeat (4) @(posedge clk);
        chk("glitch ignored", 32'(coreCtl.sysReset), 32'h0);
        debugPinIn <= 1'b0;
        repeat (4) @(posedge clk);
        chk("debug pin reset", 32'(coreCtl.sysReset), 32'h1);
        debugPinIn <= 1'b1;
        wait_idle();
        rdchk(ST, 32'h80, "status after debug pin");
        go_sleep();
        extLow <= 1'b1;
        repeat (12) @(posedge clk);
        chk("filtered pin reset", 32'(coreCtl.sysReset), 32'h1);
        extLow <= 1'b0;
        wait_idle();
        rdchk(ST, 32'h10, "status after sleep pin");
    endtask

    // Live low-voltage bit, write to status, control pin drive, unmapped slot.
    task automatic t_regs();
        lowVoltage     <= 1'b1;
        brownoutEnable <= 1'b1;
        rdchk(ST, 32'h01, "low voltage live");
        apb(1'b1, ST, 32'hFF);
        rdchk(ST, 32'h01, "low voltage kept");
        brownoutEnable <= 1'b0;
        rdchk(ST, 32'h00, "low voltage off");
        apb(1'b1, rst_ctrl_pkg::CONTROL_ADDR, 32'h2);
        @(posedge clk);
        chk("pin drive enabled", 32'(pinOe), 32'h1);
        apb(1'b1, rst_ctrl_pkg::CONTROL_ADDR, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_por();
        t_pin();
        t_wdog();
        t_dbg();
        t_wake(8'h01);
        t_wake(8'h00);
        t_wwake();
        t_glitch();
        t_regs();
        give_verdict();
    end

    // The scenarios need about 4500 cycles; this cuts a hang short.
    initial begin
        #200000;
        badCount++;
        give_verdict();
    end
endmodule

/* tb/rst_far_side.sv */
/*
 * Far side model: the external reset circuit on the open-drain pin with its pull-up,
 * and the internal oscillator that gives one tick per oscillator cycle.
 * Assumes the bench raises extLow to pull the pin low from outside.
 */
`timescale 1ns/1ns
module rst_far_side (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_b,
    // Pin drivers.
    input  wire logic pinOe,
    input  wire logic pinOut,
    input  wire logic extLow,
    // Resolved pin and oscillator tick.
    output logic      pinLevel,
    output logic      oscTick
);
    // Wired-AND with pull-up, so a released pin reads high and never a stale value.
    assign pinLevel = !((pinOe && !pinOut) || extLow);

    // The oscillator ticks every second clock, so hold counts differ from clock counts.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oscTick <= 1'b0;
        end else begin
            oscTick <= !oscTick;
        end
    end
endmodule
